//--- pkg/nmcw_pkg.sv
// Shared constants, types and register map of the network control and wake block
package nmcw_pkg;

  // Register byte addresses on the plain register port
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_NET_CTRL = 12'h000; // network_control
  localparam logic [11:0] OFS_WAKE_CFG = 12'h0b8; // wake_match_config
  localparam logic [11:0] OFS_PFC_PAUSE = 12'h100; // Transmit priority pause contents
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h104; // Sticky events, write one to clear
  localparam logic [11:0] OFS_IRQ_MASK = 12'h108; // Interrupt enables

  // Reset values
  localparam logic [31:0] RST_NET_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_PFC_PAUSE = 32'h0000_0000;

  // network_control field positions
  localparam int NC_LPI = 19; // low_power_idle_enable
  localparam int NC_FLUSH = 18; // flush_next_rx_frame
  localparam int NC_TX_PFC = 17; // send_priority_pause
  localparam int NC_RX_PFC = 16; // accept_priority_pause

  // wake_match_config field positions
  localparam int WK_GROUP = 19; // wake_on_group_hash
  localparam int WK_SLOT1 = 18; // wake_on_station_slot_one
  localparam int WK_ARP = 17; // Wake on address resolution request
  localparam int WK_SPECIAL = 16; // wake_on_special_frame
  localparam logic [31:0] WAKE_RW_MASK = 32'h000f_ffff; // Enables plus protocol address

  // Transmit priority pause register layout
  localparam int PP_VEC_LSB = 0; // Class enable vector [7:0]
  localparam int PP_QUANT_LSB = 16; // Pause quantum [31:16], used for every class
  localparam logic [31:0] PAUSE_RW_MASK = 32'hffff_00ff; // Vector and quantum, gap reads zero

  // Interrupt status bit positions
  localparam int IRQ_W = 4;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_PAUSE_SENT = 1;
  localparam int IRQ_PAUSE_RX = 2;
  localparam int IRQ_FLUSH = 3;

  // Transmit line codes
  localparam logic [3:0] LPI_TXD = 4'h1; // Idle signalling code with error high
  localparam logic [3:0] IDLE_TXD = 4'h0;

  // Pause frame layout, in byte indices from the first preamble byte
  localparam logic [6:0] FB_SFD = 7'h07;
  localparam logic [6:0] FB_DST = 7'h08;
  localparam logic [6:0] FB_SRC = 7'h0e;
  localparam logic [6:0] FB_TYPE = 7'h14;
  localparam logic [6:0] FB_OPC = 7'h16;
  localparam logic [6:0] FB_VEC = 7'h18;
  localparam logic [6:0] FB_TIMES = 7'h1a;
  localparam logic [6:0] FB_PAD = 7'h2a;
  localparam logic [6:0] FB_FCS = 7'h44;
  localparam logic [7:0] LAST_NIBBLE = 8'h8f; // 72 bytes, two nibbles each
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [47:0] PAUSE_DST = 48'h0180_c200_0001;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] PFC_OPCODE = 16'h0101;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

  // One transmit nibble of the media-independent interface
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } nmcw_mii_tx_t;

  // Match results of one received frame from the address filter
  typedef struct packed {
    logic group_hash;
    logic station_one;
    logic arp;
    logic special;
  } nmcw_hits_t;

  // Transmit sequencer states
  typedef enum logic [0:0] {
    NMCW_TX_IDLE = 1'b0,
    NMCW_TX_FRAME = 1'b1
  } nmcw_tx_state_t;

endpackage

//--- hdl/nmcw_core.sv
// Network control and wake configuration block with pause frame sender
module nmcw_core
  import nmcw_pkg::*;
#(
  parameter logic [47:0] STATION_ADDR = 48'h0200_0000_0001 // Source address, value arbitrary
) (
  input wire logic clock, // 250 MHz block clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [ADDR_W-1:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, valid the cycle after the strobe
  input wire logic tx_clk_pin, // Transmit clock from the PHY
  output nmcw_mii_tx_t mii_tx, // Transmit enable, error and nibble
  input wire logic rx_dma_busy, // Receive DMA is copying a stored frame
  output logic rx_flush, // Pulse: drop next stored received frame
  input wire logic rx_frame_done, // Pulse: a received frame completed
  input wire nmcw_hits_t rx_hits, // Filter matches of that frame
  input wire logic rx_pfc_frame, // That frame was a priority pause frame
  output logic pfc_negotiate, // Advertise priority flow control
  output logic pfc_pause_seen, // Pulse: priority pause frame recognised
  output logic wake_event, // Pulse: wake toward the system
  output logic irq // Level interrupt
);

  // Registers
  logic lpi_en; // Low power idle enable
  logic tx_pfc_pending; // Pause frame requested or in flight
  logic rx_pfc_en; // Priority pause reception enable
  logic [31:0] wake_cfg; // wake_match_config storage
  logic [31:0] pfc_pause; // Transmit priority pause contents
  logic [IRQ_W-1:0] irq_status; // Sticky events
  logic [IRQ_W-1:0] irq_mask; // Interrupt enables

  // Transmit clock synchroniser and edge finder
  logic tx_clk_s1; // First stage, read only by the second
  logic tx_clk_s2; // Second stage
  logic tx_clk_s3; // Previous sampled level
  nmcw_tx_state_t tx_state; // Sequencer state
  logic [7:0] nib_cnt; // Nibble index within the frame
  logic [31:0] crc; // Running frame check value

  // Address decode
  wire hit_ctrl = (reg_addr == OFS_NET_CTRL);
  wire hit_wake = (reg_addr == OFS_WAKE_CFG);
  wire hit_pause = (reg_addr == OFS_PFC_PAUSE);
  wire hit_status = (reg_addr == OFS_IRQ_STATUS);
  wire hit_mask = (reg_addr == OFS_IRQ_MASK);
  wire wr_ctrl = reg_wr & hit_ctrl;
  wire wr_status = reg_wr & hit_status;
  // Mask as it stands after this edge, so a mask write moves irq in the same cycle
  wire [IRQ_W-1:0] next_irq_mask = (reg_wr & hit_mask) ? reg_wdata[IRQ_W-1:0] : irq_mask;

  // Control writes that trigger actions
  wire flush_req = wr_ctrl & reg_wdata[NC_FLUSH];
  wire flush_take = flush_req & ~rx_dma_busy;
  wire pfc_req = wr_ctrl & reg_wdata[NC_TX_PFC];

  // Rising edge of the transmit clock; outputs change on it, PHY samples next rise
  wire tx_tick = tx_clk_s2 & ~tx_clk_s3;

  // Wake qualification: each match gated by its enable
  // A frame that hits several enabled criteria still gives one wake pulse
  wire wake_group = rx_hits.group_hash & wake_cfg[WK_GROUP];
  wire wake_slot1 = rx_hits.station_one & wake_cfg[WK_SLOT1];
  wire wake_arp = rx_hits.arp & wake_cfg[WK_ARP];
  wire wake_special = rx_hits.special & wake_cfg[WK_SPECIAL];
  wire wake_any = wake_group | wake_slot1 | wake_arp | wake_special;
  wire wake_fire = rx_frame_done & wake_any;
  wire pfc_fire = rx_frame_done & rx_pfc_frame & rx_pfc_en;

  // Frame progress
  wire frame_start = tx_tick & (tx_state == NMCW_TX_IDLE) & tx_pfc_pending & ~lpi_en;
  wire frame_last = tx_tick & (tx_state == NMCW_TX_FRAME) & (nib_cnt == LAST_NIBBLE);
  wire [6:0] byte_idx = nib_cnt[7:1];
  wire in_crc_span = (byte_idx >= FB_DST) & (byte_idx < FB_FCS);
  wire in_fcs = (byte_idx >= FB_FCS);

  // Pause frame byte at a given index, body only; the check value is sent separately
  function automatic logic [7:0] frame_byte(input logic [6:0] idx, input logic [31:0] pp);
    logic [6:0] rel;
    logic [7:0] b;
    rel = 7'h00;
    b = 8'h00;
    if (idx < FB_SFD) begin
      b = PREAMBLE_BYTE;
    end else if (idx == FB_SFD) begin
      b = SFD_BYTE;
    end else if (idx < FB_SRC) begin
      rel = 7'(FB_SRC - 7'h01 - idx);
      b = PAUSE_DST[rel*8 +: 8]; // Destination, most significant byte first
    end else if (idx < FB_TYPE) begin
      rel = 7'(FB_TYPE - 7'h01 - idx);
      b = STATION_ADDR[rel*8 +: 8];
    end else if (idx < FB_OPC) begin
      b = (idx == FB_TYPE) ? PAUSE_TYPE[15:8] : PAUSE_TYPE[7:0];
    end else if (idx < FB_VEC) begin
      b = (idx == FB_OPC) ? PFC_OPCODE[15:8] : PFC_OPCODE[7:0];
    end else if (idx < FB_TIMES) begin
      b = (idx == FB_VEC) ? 8'h00 : pp[PP_VEC_LSB +: 8];
    end else if (idx < FB_PAD) begin
      // Eight class timers, all carrying the programmed quantum
      b = idx[0] ? pp[PP_QUANT_LSB +: 8] : pp[PP_QUANT_LSB + 8 +: 8];
    end else begin
      b = 8'h00; // Pad to minimum length
    end
    return b;
  endfunction

  // Frame check update over one nibble, least significant bit first
  // Reflected polynomial, so the check is built in the order the nibbles leave;
  // its complement goes out after the pad, low nibble first
  function automatic logic [31:0] crc_nibble(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  wire [7:0] cur_byte = frame_byte(byte_idx, pfc_pause);
  wire [3:0] body_nib = nib_cnt[0] ? cur_byte[7:4] : cur_byte[3:0];
  wire [3:0] fcs_nib = ~crc[3:0];
  wire [3:0] tx_nib = in_fcs ? fcs_nib : body_nib;

  // Next transmit line value; LOW_POWER_IDLE_ENABLE wins over idle, a running frame completes first
  nmcw_mii_tx_t next_mii_tx;
  always_comb begin
    next_mii_tx = mii_tx;
    if (tx_tick) begin
      if (tx_state == NMCW_TX_FRAME) begin
        next_mii_tx = '{en: 1'b1, er: 1'b0, d: tx_nib};
      end else if (lpi_en) begin
        next_mii_tx = '{en: 1'b0, er: 1'b1, d: LPI_TXD};
      end else begin
        next_mii_tx = '{en: 1'b0, er: 1'b0, d: IDLE_TXD};
      end
    end
    if (frame_last) begin
      // The closing nibble goes out on the same tick that ends the frame
      next_mii_tx = '{en: 1'b1, er: 1'b0, d: tx_nib};
    end
  end

  // Next sticky status: hardware set wins over software clear
  wire [IRQ_W-1:0] ev_set = {flush_take, pfc_fire, frame_last, wake_fire};
  wire [IRQ_W-1:0] ev_clr = wr_status ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~ev_clr) | ev_set;

  // Read multiplexer; unmapped addresses read zero
  wire [31:0] ctrl_view = (32'(lpi_en) << NC_LPI) | (32'(tx_pfc_pending) << NC_TX_PFC)
                        | (32'(rx_pfc_en) << NC_RX_PFC);
  wire [31:0] next_rdata = hit_ctrl ? ctrl_view :
                           hit_wake ? wake_cfg :
                           hit_pause ? pfc_pause :
                           hit_status ? 32'(irq_status) :
                           hit_mask ? 32'(irq_mask) : 32'h0000_0000;

  // Register bus: read data stands only in the cycle after the strobe
  // Returning to zero afterwards keeps back-to-back reads free of stale values
  // and lets the master take the word without any wait state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // Configuration registers
  // Flush and send-pause are actions and are not stored here
  // Writes to unmapped addresses fall through every decode and are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lpi_en <= RST_NET_CTRL[NC_LPI];
      rx_pfc_en <= RST_NET_CTRL[NC_RX_PFC];
      wake_cfg <= RST_WAKE_CFG;
      pfc_pause <= RST_PFC_PAUSE;
      irq_mask <= {IRQ_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        lpi_en <= reg_wdata[NC_LPI];
        rx_pfc_en <= reg_wdata[NC_RX_PFC];
      end
      if (reg_wr & hit_wake) begin
        wake_cfg <= reg_wdata & WAKE_RW_MASK;
      end
      if (reg_wr & hit_pause) begin
        pfc_pause <= reg_wdata & PAUSE_RW_MASK; // Gap between vector and quantum reads zero
      end
      irq_mask <= next_irq_mask;
    end
  end

  // Pause request stays pending until its frame ends; a new request then wins
  // Writing zero to the send bit has no effect: software cannot cancel a
  // requested frame, which keeps a half-sent frame off the line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_pfc_pending <= RST_NET_CTRL[NC_TX_PFC];
    end else if (pfc_req) begin
      tx_pfc_pending <= 1'b1;
    end else if (frame_last) begin
      tx_pfc_pending <= 1'b0;
    end
  end

  // Transmit clock: two stages before any logic, then edge history
  // The pin is unrelated to the block clock; only the second stage feeds logic,
  // so a metastable first stage settles before any decision is taken on it.
  // The history stage adds no latency, as the tick is taken from the second stage, and yields a clean one-cycle tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_clk_s1 <= 1'b0;
      tx_clk_s2 <= 1'b0;
      tx_clk_s3 <= 1'b0;
    end else begin
      tx_clk_s1 <= tx_clk_pin;
      tx_clk_s2 <= tx_clk_s1;
      tx_clk_s3 <= tx_clk_s2;
    end
  end

  // Transmit sequencer
  // The counter advances only on ticks, so the frame length does not depend
  // on the ratio between the block clock and the link clock.
  // A request raised mid-frame is cleared when that frame ends; only one in its last-tick cycle starts another
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_state <= NMCW_TX_IDLE;
      nib_cnt <= 8'h00;
      crc <= CRC_INIT;
    end else begin
      case (tx_state)
        NMCW_TX_IDLE: begin
          if (frame_start) begin
            tx_state <= NMCW_TX_FRAME;
            nib_cnt <= 8'h00;
            crc <= CRC_INIT;
          end
        end
        NMCW_TX_FRAME: begin
          if (frame_last) begin
            tx_state <= NMCW_TX_IDLE;
          end else if (tx_tick) begin
            nib_cnt <= nib_cnt + 8'h01;
            // Check value accumulates over the body, then shifts out a nibble at a time
            if (in_crc_span) begin
              crc <= crc_nibble(crc, body_nib);
            end else if (in_fcs) begin
              crc <= crc >> 4;
            end
          end
        end
        default: begin
          tx_state <= NMCW_TX_IDLE;
        end
      endcase
    end
  end

  // Line outputs and event pulses
  // Every output leaves a flip-flop, so the far side sees no decode glitches;
  // a flush written while the receive DMA is busy leaves no trace at all
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mii_tx <= '{en: 1'b0, er: 1'b0, d: IDLE_TXD};
      rx_flush <= 1'b0;
      wake_event <= 1'b0;
      pfc_pause_seen <= 1'b0;
      pfc_negotiate <= 1'b0;
    end else begin
      mii_tx <= next_mii_tx;
      rx_flush <= flush_take;
      wake_event <= wake_fire;
      pfc_pause_seen <= pfc_fire;
      pfc_negotiate <= rx_pfc_en;
    end
  end

  // Interrupt status and output
  // irq follows the next status and mask, so it moves in the same cycle as they do;
  // a masked event is still recorded and raises irq once it is unmasked
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= {IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

endmodule // nmcw_core

//--- verif/nmcw_core_props.sv
// Concurrent checks on the ports of the network control and wake block
module nmcw_core_props
  import nmcw_pkg::*;
(
  input wire logic clock, // Block clock
  input wire logic rst, // Asynchronous reset
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic tx_clk_pin, // Link clock
  input wire nmcw_mii_tx_t mii_tx, // Transmit lines
  input wire logic rx_dma_busy, // Receive DMA busy
  input wire logic rx_flush, // Flush pulse
  input wire logic rx_frame_done, // Frame done pulse
  input wire nmcw_hits_t rx_hits, // Filter hits
  input wire logic rx_pfc_frame, // Priority pause frame
  input wire logic pfc_negotiate, // Negotiate level
  input wire logic pfc_pause_seen, // Pause seen pulse
  input wire logic wake_event, // Wake pulse
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Flush request on the control word
  sequence s_flush_wr;
    reg_wr && reg_addr == OFS_NET_CTRL && reg_wdata[NC_FLUSH];
  endsequence
  // Pause frame arriving while reception was enabled in both cycles
  sequence s_pfc_on;
    rx_frame_done && rx_pfc_frame && pfc_negotiate ##1 pfc_negotiate;
  endsequence
  property p_flush_go;
    s_flush_wr ##0 !rx_dma_busy |=> rx_flush ##1 !rx_flush;
  endproperty
  a_flush_go: assert property (p_flush_go) else $error("flush pulse wrong");
  property p_flush_busy;
    s_flush_wr ##0 rx_dma_busy |=> !rx_flush;
  endproperty
  a_flush_busy: assert property (p_flush_busy) else $error("flush while busy");
  property p_flush_cause;
    !(reg_wr && reg_addr == OFS_NET_CTRL && reg_wdata[NC_FLUSH]) |=> !rx_flush;
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("stray flush");
  property p_pause_seen;
    s_pfc_on |-> pfc_pause_seen;
  endproperty
  a_pause_seen: assert property (p_pause_seen) else $error("pause missed");
  property p_pause_cause;
    !(rx_frame_done && rx_pfc_frame) |=> !pfc_pause_seen;
  endproperty
  a_pause_cause: assert property (p_pause_cause) else $error("stray pause");
  // Negotiation follows the enable bit one cycle after the write lands
  property p_negotiate;
    reg_wr && reg_addr == OFS_NET_CTRL |-> ##2 pfc_negotiate == $past(reg_wdata[NC_RX_PFC], 2);
  endproperty
  a_negotiate: assert property (p_negotiate) else $error("negotiate wrong");
  property p_wake_cause;
    !(rx_frame_done && |rx_hits) |=> !wake_event;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("stray wake");
  property p_lpi;
    mii_tx.er |-> !mii_tx.en && mii_tx.d == LPI_TXD;
  endproperty
  a_lpi: assert property (p_lpi) else $error("idle code wrong");
  property p_idle;
    !mii_tx.en && !mii_tx.er |-> mii_tx.d == IDLE_TXD;
  endproperty
  a_idle: assert property (p_idle) else $error("idle nibble wrong");
  property p_reset;
    $fell(rst) |-> mii_tx == '0 && !pfc_negotiate && !wake_event && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not quiet");
endmodule // nmcw_core_props

//--- verif/nmcw_phy_model.sv
// Link partner model: free transmit clock and nibble capture
module nmcw_phy_model
  import nmcw_pkg::*;
(
  output logic tx_clk_pin, // Transmit clock toward the block
  input wire nmcw_mii_tx_t mii_tx // Nibbles from the block
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bytes [0:127]; // Captured frame bytes
  int n_nib = 0; // Nibbles in the latest frame
  logic en_q = 1'b0; // Enable at the previous rise
  // The link clock runs free, as a real transmitter clock does
  initial begin
    tx_clk_pin = 1'b0;
    forever #62.5 tx_clk_pin = ~tx_clk_pin;
  end
  // Sample on the rise; the block moves lines well after it, low nibble first
  always @(posedge tx_clk_pin) begin
    if (mii_tx.en && !en_q) begin
      n_nib = 0;
    end
    if (mii_tx.en) begin
      if (n_nib[0]) bytes[n_nib / 2][7:4] = mii_tx.d;
      else bytes[n_nib / 2][3:0] = mii_tx.d;
      n_nib = n_nib + 1;
    end
    en_q = mii_tx.en;
  end
endmodule // nmcw_phy_model

//--- verif/nmcw_core_tb.sv
// Self-checking bench of the network control and wake block
module nmcw_core_tb
  import nmcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rx_dma_busy = 1'b0, rx_frame_done = 1'b0, rx_pfc_frame = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, v;
  nmcw_hits_t rx_hits = '0;
  nmcw_mii_tx_t mii_tx;
  logic tx_clk_pin, rx_flush, pfc_negotiate, pfc_pause_seen, wake_event, irq;
  int n_mismatch = 0, n_tests = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} nmcw_row_t;
  // Write value and expected read-back; reserved bits must read zero
  nmcw_row_t rows [5] = '{'{OFS_WAKE_CFG, 32'hffff_ffff, WAKE_RW_MASK},
    '{OFS_NET_CTRL, 32'hfff9_ffff, 32'h0009_0000},
    '{OFS_PFC_PAUSE, 32'h1234_5678, 32'h1234_0078},
    '{OFS_IRQ_MASK, 32'hffff_ffff, 32'h0000_000f}, '{12'h0fc, 32'hffff_ffff, 32'h0}};
  nmcw_core uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clk_pin(tx_clk_pin),
    .mii_tx(mii_tx), .rx_dma_busy(rx_dma_busy), .rx_flush(rx_flush),
    .rx_frame_done(rx_frame_done), .rx_hits(rx_hits), .rx_pfc_frame(rx_pfc_frame),
    .pfc_negotiate(pfc_negotiate), .pfc_pause_seen(pfc_pause_seen),
    .wake_event(wake_event), .irq(irq));
  nmcw_phy_model phy (.tx_clk_pin(tx_clk_pin), .mii_tx(mii_tx));
  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // A bounded wait that ran out ends the run at once
  task automatic expire(input logic done);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic frame(input logic [3:0] h, input logic pf, input logic ew, input logic ep);
    @(posedge clock);
    rx_frame_done <= 1'b1;
    rx_hits <= h;
    rx_pfc_frame <= pf;
    @(posedge clock);
    rx_frame_done <= 1'b0;
    #1 chk_bit(wake_event, ew);
    chk_bit(pfc_pause_seen, ep);
  endtask
  initial begin
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_NET_CTRL, v);
    chk(v, RST_NET_CTRL);
    rd(OFS_WAKE_CFG, v);
    chk(v, RST_WAKE_CFG);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Low power idle was switched on by the table
    for (int i = 0; i < 200 && !mii_tx.er; i++) @(posedge clock);
    expire(mii_tx.er);
    chk({26'h0, mii_tx}, {28'h1, LPI_TXD});
    wr(OFS_NET_CTRL, 32'h0001_0000);
    repeat (3) @(posedge clock);
    chk_bit(pfc_negotiate, 1'b1);
    frame(4'h0, 1'b1, 1'b0, 1'b1);
    frame(4'h0, 1'b0, 1'b0, 1'b0);
    wr(OFS_PFC_PAUSE, 32'h0003_00a5);
    wr(OFS_NET_CTRL, 32'h0002_0000);
    for (int i = 0; i < 500 && !mii_tx.en; i++) @(posedge clock);
    expire(mii_tx.en);
    for (int i = 0; i < 6000 && mii_tx.en; i++) @(posedge clock);
    expire(!mii_tx.en);
    chk(32'(phy.n_nib), 32'd144);
    chk({phy.bytes[0], phy.bytes[FB_SFD]}, {16'h0, PREAMBLE_BYTE, SFD_BYTE});
    chk({phy.bytes[FB_TYPE], phy.bytes[FB_VEC + 7'h1]}, 32'h88a5);
    chk({phy.bytes[FB_TIMES], phy.bytes[FB_TIMES + 7'h1]}, 32'h0003);
    rd(OFS_NET_CTRL, v);
    chk(v, 32'h0);
    rd(OFS_IRQ_STATUS, v);
    chk(v & 32'h2, 32'h2);
    wr(OFS_NET_CTRL, 32'h0004_0000);
    #1 chk_bit(rx_flush, 1'b1);
    @(posedge clock) rx_dma_busy <= 1'b1;
    wr(OFS_NET_CTRL, 32'h0004_0000);
    #1 chk_bit(rx_flush, 1'b0);
    wr(OFS_IRQ_STATUS, 32'h0000_000f);
    #1 chk_bit(irq, 1'b0);
    // Each wake enable alone: its own hit wakes, every other hit does not
    for (int i = 0; i < 4; i++) begin
      wr(OFS_WAKE_CFG, 32'h1 << (16 + i));
      frame(4'h1 << i, 1'b0, 1'b1, 1'b0);
      frame(~(4'h1 << i), 1'b0, 1'b0, 1'b0);
    end
    chk_bit(irq, 1'b1);
    wr(OFS_IRQ_MASK, 32'h0);
    #1 chk_bit(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h1);
    #1 chk_bit(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h1);
    #1 chk_bit(irq, 1'b0);
    wr(OFS_WAKE_CFG, 32'h0);
    frame(4'hf, 1'b0, 1'b0, 1'b0);
    wr(OFS_NET_CTRL, 32'h0001_0000);
    // Second reset in mid-run clears the control word again
    @(posedge clock) rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_NET_CTRL, v);
    chk(v, RST_NET_CTRL);
    end_of_test();
  end
endmodule // nmcw_core_tb
bind nmcw_core nmcw_core_props chk_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_clk_pin(tx_clk_pin), .mii_tx(mii_tx), .rx_dma_busy(rx_dma_busy), .rx_flush(rx_flush),
  .rx_frame_done(rx_frame_done), .rx_hits(rx_hits), .rx_pfc_frame(rx_pfc_frame),
  .pfc_negotiate(pfc_negotiate), .pfc_pause_seen(pfc_pause_seen),
  .wake_event(wake_event), .irq(irq));
